// >>> logic/uocr_pkg.sv
// Shared constants for the offload control register port and its user end.
// Assumes one clock for both ends; no vendor primitives.
package uocr_pkg;
  // Register port addresses
  localparam logic [3:0] ADDR_RESET_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_SEND_COMMAND = 4'h1;
  localparam logic [3:0] ADDR_LOCAL_MAC_LOW = 4'h2;
  localparam logic [3:0] ADDR_LOCAL_MAC_HIGH = 4'h3;
  localparam logic [3:0] ADDR_REMOTE_IP_ADDR = 4'h4;
  localparam logic [3:0] ADDR_LOCAL_IP_ADDR = 4'h5;
  localparam logic [3:0] ADDR_REMOTE_PORT_PAIR = 4'h6;
  localparam logic [3:0] ADDR_LOCAL_PORT = 4'h7;
  localparam logic [3:0] ADDR_TX_TOTAL_LENGTH = 4'h8;
  localparam logic [3:0] ADDR_ARP_TIMEOUT_STATUS = 4'h9;
  localparam logic [3:0] ADDR_TX_PACKET_LENGTH = 4'ha;
  localparam logic [3:0] ADDR_ROLE_SELECT = 4'he;
  localparam logic [3:0] ADDR_CORE_VERSION = 4'hf;
  // Reset values
  localparam logic RESET_CONTROL_RST = 1'b1;
  localparam logic ROLE_SELECT_RST = 1'b0;
  localparam logic [15:0] TX_PACKET_LENGTH_RST = 16'h05c0;
  localparam logic [31:0] ARP_TIMEOUT_RST = 32'h00006001;
  // Event-cause bit positions in the timeout/status read value
  localparam int STAT_ARP_TIMEOUT = 0;
  localparam int STAT_DROP_BUF_FULL = 8;
  localparam int STAT_DROP_CHECKSUM = 9;
  localparam int STAT_DROP_MAC_ERR = 10;
  // Host controller APB byte offsets
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_WDATA = 8'h04;
  localparam logic [7:0] APB_RDATA = 8'h08;
  localparam logic [7:0] APB_STATUS = 8'h0c;
  localparam logic [7:0] APB_TX_BYTE = 8'h10;
  localparam logic [7:0] APB_RX_BYTE = 8'h14;
  // Host control word fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_ADDR_LSB = 4;
  // Host status bits
  localparam int HST_PENDING = 0;
  localparam int HST_BUSY = 1;
  localparam int HST_REFUSED = 2;
  localparam int HST_IRQ = 3;
  localparam int HST_TX_FULL = 4;
  localparam int HST_RX_EMPTY = 5;
endpackage : uocr_pkg

// >>> logic/uocr_if.sv
// Register port and payload FIFO port between user logic and the core.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface uocr_if;
  logic [3:0] reg_port_address;
  logic [31:0] reg_port_write_data;
  logic reg_port_write_enable;
  logic [31:0] reg_port_read_data;
  logic busy;
  logic interrupt_out;
  // Byte-wide payload FIFO ports
  logic tx_payload_fifo_wr_en;
  logic [7:0] tx_payload_fifo_wr_data;
  logic tx_payload_fifo_full;
  logic rx_payload_fifo_rd_en;
  logic [7:0] rx_payload_fifo_rd_data;
  logic rx_payload_fifo_empty;

  modport dev
  (
    input reg_port_address, reg_port_write_data, reg_port_write_enable,
    input tx_payload_fifo_wr_en, tx_payload_fifo_wr_data,
    input rx_payload_fifo_rd_en,
    output reg_port_read_data, busy, interrupt_out,
    output tx_payload_fifo_full, rx_payload_fifo_rd_data,
    output rx_payload_fifo_empty
  );

  modport usr
  (
    output reg_port_address, reg_port_write_data, reg_port_write_enable,
    output tx_payload_fifo_wr_en, tx_payload_fifo_wr_data,
    output rx_payload_fifo_rd_en,
    input reg_port_read_data, busy, interrupt_out,
    input tx_payload_fifo_full, rx_payload_fifo_rd_data,
    input rx_payload_fifo_empty
  );
endinterface : uocr_if

// >>> logic/uocr_core_regs.sv
// Core end: register bank, start-up ARP sequencer and send tracking.
// Assumes packet engine signals on the same clock, event inputs as one-cycle pulses, ready and empty as levels.
//
// Summary of operation
// - 4-bit address, 32-bit data, RAM-like port
// - Reset control defaults 1; 0 starts init
// - Host toggles reset control after parameter changes
// - Command bit 0 written 1 starts send
// - Command read bit 0 equals busy pin
// - Host waits idle before new send
// - Own MAC split low and high registers
// - Remote and own IPv4 address registers
// - Send and receive remote ports, one register
// - Own UDP port in low half
// - Total length latched at send command
// - Total length read gives bytes remaining
// - ARP wait in ticks; timeout raises interrupt
// - Keep resending ARP request until reply
// - Status read reports timeout and drop causes
// - Packet length 1-16000, reset 1472
// - Host never writes packet length while busy
// - Client role requests ARP, idles on reply
// - Server role waits request, replies, idles
// - Remote resends ARP request in server role
// - Byte-wide payload FIFO ports both ways
// - Read data valid one cycle after address
// - Write address and data with enable
`timescale 1ns/1ps
module uocr_core_regs
  import uocr_pkg::*;
#(
  parameter logic [31:0] CORE_VERSION = 32'h00010000 // Arbitrary value
)
(
  input wire logic pclk,
  input wire logic presetn,
  uocr_if.dev ifc,
  input wire logic net_tx_byte_done,
  input wire logic net_arp_reply_rx,
  input wire logic net_arp_request_rx,
  input wire logic net_drop_buf_full,
  input wire logic net_drop_checksum,
  input wire logic mac_rx_error_flag,
  input wire logic net_tx_ready,
  input wire logic [7:0] net_rx_data,
  input wire logic net_rx_empty,
  output logic net_arp_request_tx,
  output logic net_arp_reply_tx,
  output logic net_link_ready,
  output logic [47:0] net_local_mac,
  output logic [31:0] net_remote_ip,
  output logic [31:0] net_local_ip,
  output logic [31:0] net_remote_ports,
  output logic [15:0] net_local_port,
  output logic net_role_server,
  output logic [15:0] net_packet_length,
  output logic net_tx_valid,
  output logic [7:0] net_tx_data,
  output logic net_rx_pop
);
  import uocr_pkg::*;

  typedef enum logic [2:0] {
    ST_HOLD, ST_ARP_SEND, ST_ARP_WAIT, ST_SERVER_WAIT, ST_READY
  } uocr_init_t;

  uocr_init_t state_q;
  logic reset_control_q;
  logic role_select_q;
  logic [31:0] mac_low_q, remote_ip_q, local_ip_q, ports_q, total_q;
  logic [15:0] mac_high_q, local_port_q, pkt_len_q;
  logic [31:0] timeout_q, timer_q, remain_q;
  logic [10:0] cause_q;
  logic send_busy_q;
  logic [31:0] rdata_d;
  logic wr, status_rd, start_send;

  assign wr = ifc.reg_port_write_enable;
  assign status_rd = !wr &&
    ifc.reg_port_address == ADDR_ARP_TIMEOUT_STATUS;
  assign start_send = wr && ifc.reg_port_address == ADDR_SEND_COMMAND &&
    ifc.reg_port_write_data[0] && state_q == ST_READY && !send_busy_q;

  // Software-written configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_control_q <= RESET_CONTROL_RST;
      role_select_q <= ROLE_SELECT_RST;
      pkt_len_q <= TX_PACKET_LENGTH_RST;
      timeout_q <= ARP_TIMEOUT_RST;
      mac_low_q <= 32'h0;
      mac_high_q <= 16'h0;
      remote_ip_q <= 32'h0;
      local_ip_q <= 32'h0;
      ports_q <= 32'h0;
      local_port_q <= 16'h0;
      total_q <= 32'h0;
    end
    else if (wr)
    begin
      // Unlisted addresses fall through with no effect
      if (ifc.reg_port_address == ADDR_RESET_CONTROL)
        reset_control_q <= ifc.reg_port_write_data[0];
      else if (ifc.reg_port_address == ADDR_LOCAL_MAC_LOW)
        mac_low_q <= ifc.reg_port_write_data;
      else if (ifc.reg_port_address == ADDR_LOCAL_MAC_HIGH)
        mac_high_q <= ifc.reg_port_write_data[15:0];
      else if (ifc.reg_port_address == ADDR_REMOTE_IP_ADDR)
        remote_ip_q <= ifc.reg_port_write_data;
      else if (ifc.reg_port_address == ADDR_LOCAL_IP_ADDR)
        local_ip_q <= ifc.reg_port_write_data;
      else if (ifc.reg_port_address == ADDR_REMOTE_PORT_PAIR)
        ports_q <= ifc.reg_port_write_data;
      else if (ifc.reg_port_address == ADDR_LOCAL_PORT)
        local_port_q <= ifc.reg_port_write_data[15:0];
      else if (ifc.reg_port_address == ADDR_TX_TOTAL_LENGTH)
        total_q <= ifc.reg_port_write_data;
      else if (ifc.reg_port_address == ADDR_ARP_TIMEOUT_STATUS)
        timeout_q <= ifc.reg_port_write_data;
      else if (ifc.reg_port_address == ADDR_TX_PACKET_LENGTH)
        pkt_len_q <= ifc.reg_port_write_data[15:0];
      else if (ifc.reg_port_address == ADDR_ROLE_SELECT)
        role_select_q <= ifc.reg_port_write_data[0];
    end
  end

  // Network parameters other than packet length are copied only when reset control drops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      net_local_mac <= 48'h0;
      net_remote_ip <= 32'h0;
      net_local_ip <= 32'h0;
      net_remote_ports <= 32'h0;
      net_local_port <= 16'h0;
      net_role_server <= 1'b0;
      net_packet_length <= TX_PACKET_LENGTH_RST;
    end
    else
    begin
      if (state_q == ST_HOLD && !reset_control_q)
      begin
        net_local_mac <= {mac_high_q, mac_low_q};
        net_remote_ip <= remote_ip_q;
        net_local_ip <= local_ip_q;
        net_remote_ports <= ports_q;
        net_local_port <= local_port_q;
        net_role_server <= role_select_q;
      end
      // Packet length follows live; host keeps it still while busy
      net_packet_length <= pkt_len_q;
    end
  end

  // Start-up sequencer; a write of 1 to reset control sends it back to hold
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_HOLD;
      timer_q <= 32'h0;
      net_arp_request_tx <= 1'b0;
      net_arp_reply_tx <= 1'b0;
    end
    else
    begin
      net_arp_request_tx <= 1'b0;
      net_arp_reply_tx <= 1'b0;
      if (reset_control_q)
        state_q <= ST_HOLD;
      else
        case (state_q)
          ST_HOLD:
            state_q <= role_select_q ? ST_SERVER_WAIT : ST_ARP_SEND;
          ST_ARP_SEND:
          begin
            net_arp_request_tx <= 1'b1;
            timer_q <= 32'h0;
            state_q <= ST_ARP_WAIT;
          end
          ST_ARP_WAIT:
          begin
            timer_q <= timer_q + 32'h1;
            if (net_arp_reply_rx)
              state_q <= ST_READY;
            else if (timer_q >= timeout_q)
              state_q <= ST_ARP_SEND; // Resend until answered
          end
          ST_SERVER_WAIT:
            // Relies on the remote asking again after release
            if (net_arp_request_rx)
            begin
              net_arp_reply_tx <= 1'b1;
              state_q <= ST_READY;
            end
          default:
            state_q <= ST_READY;
        endcase
    end
  end

  // Send tracking; remaining count drops per byte handed off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      send_busy_q <= 1'b0;
      remain_q <= 32'h0;
    end
    else if (state_q != ST_READY)
    begin
      send_busy_q <= 1'b0;
      remain_q <= 32'h0;
    end
    else if (start_send)
    begin
      send_busy_q <= 1'b1;
      // Value written in the same cycle is not yet visible in total_q
      remain_q <= total_q;
    end
    else if (send_busy_q && net_tx_byte_done)
    begin
      remain_q <= remain_q - 32'h1;
      if (remain_q == 32'h1)
        send_busy_q <= 1'b0;
    end
  end

  // Sticky causes; a set in the clearing read cycle is kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cause_q <= 11'h0;
    else
    begin
      if (status_rd)
        cause_q <= 11'h0;
      if (state_q == ST_ARP_WAIT && !net_arp_reply_rx &&
          timer_q >= timeout_q)
        cause_q[STAT_ARP_TIMEOUT] <= 1'b1;
      if (net_drop_buf_full)
        cause_q[STAT_DROP_BUF_FULL] <= 1'b1;
      if (net_drop_checksum)
        cause_q[STAT_DROP_CHECKSUM] <= 1'b1;
      if (mac_rx_error_flag)
        cause_q[STAT_DROP_MAC_ERR] <= 1'b1;
    end
  end

  // Read mux; address decode is registered one cycle later
  always_comb
  begin
    rdata_d = 32'h0;
    if (ifc.reg_port_address == ADDR_RESET_CONTROL)
      rdata_d = {31'h0, reset_control_q};
    else if (ifc.reg_port_address == ADDR_SEND_COMMAND)
      rdata_d = {31'h0, ifc.busy};
    else if (ifc.reg_port_address == ADDR_LOCAL_MAC_LOW)
      rdata_d = mac_low_q;
    else if (ifc.reg_port_address == ADDR_LOCAL_MAC_HIGH)
      rdata_d = {16'h0, mac_high_q};
    else if (ifc.reg_port_address == ADDR_REMOTE_IP_ADDR)
      rdata_d = remote_ip_q;
    else if (ifc.reg_port_address == ADDR_LOCAL_IP_ADDR)
      rdata_d = local_ip_q;
    else if (ifc.reg_port_address == ADDR_REMOTE_PORT_PAIR)
      rdata_d = ports_q;
    else if (ifc.reg_port_address == ADDR_LOCAL_PORT)
      rdata_d = {16'h0, local_port_q};
    else if (ifc.reg_port_address == ADDR_TX_TOTAL_LENGTH)
      rdata_d = remain_q;
    else if (ifc.reg_port_address == ADDR_ARP_TIMEOUT_STATUS)
      rdata_d = {21'h0, cause_q};
    else if (ifc.reg_port_address == ADDR_TX_PACKET_LENGTH)
      rdata_d = {16'h0, pkt_len_q};
    else if (ifc.reg_port_address == ADDR_ROLE_SELECT)
      rdata_d = {31'h0, role_select_q};
    else if (ifc.reg_port_address == ADDR_CORE_VERSION)
      rdata_d = CORE_VERSION;
  end

  // Registered outputs toward user logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ifc.reg_port_read_data <= 32'h0;
      ifc.busy <= 1'b1;
      ifc.interrupt_out <= 1'b0;
      net_link_ready <= 1'b0;
    end
    else
    begin
      ifc.reg_port_read_data <= rdata_d;
      // Busy covers start-up and a send, including the start cycle
      ifc.busy <= (state_q != ST_READY) || send_busy_q ||
        start_send;
      ifc.interrupt_out <= cause_q[STAT_ARP_TIMEOUT];
      net_link_ready <= state_q == ST_READY;
    end
  end

  // Payload byte ports, one register stage each way
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      net_tx_valid <= 1'b0;
      net_tx_data <= 8'h0;
      ifc.tx_payload_fifo_full <= 1'b1;
      net_rx_pop <= 1'b0;
      ifc.rx_payload_fifo_rd_data <= 8'h0;
      ifc.rx_payload_fifo_empty <= 1'b1;
    end
    else
    begin
      net_tx_valid <= ifc.tx_payload_fifo_wr_en &&
        !ifc.tx_payload_fifo_full;
      net_tx_data <= ifc.tx_payload_fifo_wr_data;
      // Full holds one extra cycle after ready drops; engine absorbs it
      ifc.tx_payload_fifo_full <= !net_tx_ready;
      net_rx_pop <= ifc.rx_payload_fifo_rd_en &&
        !ifc.rx_payload_fifo_empty;
      if (ifc.rx_payload_fifo_rd_en && !ifc.rx_payload_fifo_empty)
        ifc.rx_payload_fifo_rd_data <= net_rx_data;
      ifc.rx_payload_fifo_empty <= net_rx_empty || net_rx_pop;
    end
  end
endmodule : uocr_core_regs

// >>> logic/uocr_user_ctrl.sv
// User end: APB slave that turns software orders into register port
// accesses and payload byte moves. Assumes APB on the core's clock.
`timescale 1ns/1ps
module uocr_user_ctrl
  import uocr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  uocr_if.usr ifc,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import uocr_pkg::*;

  typedef enum logic [1:0] {
    HS_IDLE, HS_READ_WAIT, HS_READ_TAKE
  } uocr_host_t;

  uocr_host_t state_q;
  logic [31:0] wdata_q, rdata_q;
  logic [7:0] rx_byte_q;
  logic refused_q, rx_take_q;
  logic [31:0] prdata_d;
  logic apb_wr, go, guarded;
  logic [3:0] go_addr;

  assign apb_wr = psel && penable && pready && pwrite;
  assign go = apb_wr && paddr == APB_CTRL && pwdata[CTRL_GO];
  assign go_addr = pwdata[CTRL_ADDR_LSB +: 4];
  // Send and packet-length writes are refused while busy
  assign guarded = pwdata[CTRL_WRITE] && ifc.busy &&
    ((go_addr == ADDR_SEND_COMMAND && wdata_q[0]) ||
     go_addr == ADDR_TX_PACKET_LENGTH);

  // One register port access per order
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= HS_IDLE;
      ifc.reg_port_address <= 4'h0;
      ifc.reg_port_write_data <= 32'h0;
      ifc.reg_port_write_enable <= 1'b0;
      rdata_q <= 32'h0;
      refused_q <= 1'b0;
    end
    else
    begin
      ifc.reg_port_write_enable <= 1'b0;
      case (state_q)
        HS_IDLE:
          if (go)
          begin
            refused_q <= guarded;
            if (!guarded)
            begin
              // Address, data and enable leave together
              ifc.reg_port_address <= go_addr;
              ifc.reg_port_write_data <= wdata_q;
              ifc.reg_port_write_enable <= pwdata[CTRL_WRITE];
              if (!pwdata[CTRL_WRITE])
                state_q <= HS_READ_WAIT;
            end
          end
        HS_READ_WAIT:
          state_q <= HS_READ_TAKE;
        default:
        begin
          rdata_q <= ifc.reg_port_read_data;
          state_q <= HS_IDLE;
        end
      endcase
    end
  end

  // Payload pushes and pops ordered by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdata_q <= 32'h0;
      ifc.tx_payload_fifo_wr_en <= 1'b0;
      ifc.tx_payload_fifo_wr_data <= 8'h0;
      ifc.rx_payload_fifo_rd_en <= 1'b0;
      rx_take_q <= 1'b0;
      rx_byte_q <= 8'h0;
    end
    else
    begin
      if (apb_wr && paddr == APB_WDATA)
        wdata_q <= pwdata;
      // A byte ordered while full is dropped here and never reaches the core
      ifc.tx_payload_fifo_wr_en <= apb_wr && paddr == APB_TX_BYTE &&
        !ifc.tx_payload_fifo_full;
      if (apb_wr && paddr == APB_TX_BYTE)
        ifc.tx_payload_fifo_wr_data <= pwdata[7:0];
      ifc.rx_payload_fifo_rd_en <= apb_wr && paddr == APB_RX_BYTE &&
        !ifc.rx_payload_fifo_empty;
      rx_take_q <= ifc.rx_payload_fifo_rd_en;
      if (rx_take_q)
        rx_byte_q <= ifc.rx_payload_fifo_rd_data;
    end
  end

  // APB read mux; unmapped offsets read zero
  always_comb
  begin
    prdata_d = 32'h0;
    if (paddr == APB_WDATA)
      prdata_d = wdata_q;
    else if (paddr == APB_RDATA)
      prdata_d = rdata_q;
    else if (paddr == APB_STATUS)
    begin
      prdata_d[HST_PENDING] = state_q != HS_IDLE;
      prdata_d[HST_BUSY] = ifc.busy;
      prdata_d[HST_REFUSED] = refused_q;
      prdata_d[HST_IRQ] = ifc.interrupt_out;
      prdata_d[HST_TX_FULL] = ifc.tx_payload_fifo_full;
      prdata_d[HST_RX_EMPTY] = ifc.rx_payload_fifo_empty;
    end
    else if (paddr == APB_RX_BYTE)
      prdata_d = {24'h0, rx_byte_q};
  end

  // No wait state: ready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable)
        prdata <= prdata_d;
    end
  end
endmodule : uocr_user_ctrl

// >>> verif/uocr_ctl_sva.sv
// Checker on the register port joining user end and core end.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module uocr_ctl_chk
  import uocr_pkg::*;
#(
  parameter logic [31:0] CORE_VERSION = 32'h00010000
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] reg_port_address,
  input wire logic [31:0] reg_port_write_data,
  input wire logic reg_port_write_enable,
  input wire logic [31:0] reg_port_read_data,
  input wire logic busy,
  input wire logic interrupt_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Written value must come back when the address is held after the write
  property wr_rd_p;
    logic [31:0] v;
    logic [3:0] a;
    (reg_port_write_enable && reg_port_address inside {2, 4, 5, 6},
      v = reg_port_write_data, a = reg_port_address)
      ##1 reg_port_address == a |=> reg_port_read_data == v;
  endproperty

  write_read_a: assert property (wr_rd_p)
    else $error("read after write differs");
  busy_read_a: assert property (reg_port_address == 4'h1 |=>
    reg_port_read_data[0] == $past(busy)) else $error("busy bit wrong");
  unmapped_zero_a: assert property (
    reg_port_address inside {4'hb, 4'hc, 4'hd} |=> reg_port_read_data == 0)
    else $error("unmapped read not zero");
  version_read_a: assert property (
    reg_port_address == 4'hf |=> reg_port_read_data == CORE_VERSION)
    else $error("version read wrong");
  half_width_a: assert property (
    reg_port_address inside {4'h3, 4'h7, 4'ha} |=>
    reg_port_read_data[31:16] == 16'h0) else $error("upper half not zero");
  init_busy_a: assert property (reg_port_write_enable &&
    reg_port_address == 4'h0 && reg_port_write_data[0] |-> ##3 busy)
    else $error("busy low in held reset");
  send_busy_a: assert property (reg_port_write_enable &&
    reg_port_address == 4'h1 && reg_port_write_data[0] && !busy |=> busy)
    else $error("send did not raise busy");
  irq_busy_a: assert property ($rose(interrupt_out) |-> busy)
    else $error("timeout outside start-up");
  irq_clear_a: assert property ($fell(interrupt_out) |->
    $past(reg_port_address, 2) == 4'h9 || $past(reg_port_address) == 4'h9)
    else $error("timeout cause lost unread");

  // Main scenarios reached
  cover property ($rose(interrupt_out));
  cover property (reg_port_write_enable && reg_port_address == 4'h1);
  cover property ($fell(busy));
endmodule : uocr_ctl_chk

// >>> verif/tb.sv
// Bench: APB host end facing the core end, net events driven as pulses, ready and empty tied off.
// Assumes pclk at 100 MHz and the bench as the only APB master.
`timescale 1ns/1ps
module tb;
  import uocr_pkg::*;
  localparam logic [31:0] VERSION = 32'h0bad0123; // Arbitrary value
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, tx_valid, req_tx, rep_tx;
  logic srole;
  logic [5:0] np;
  logic [7:0] paddr, tx_data, tx_last, rx_byte;
  logic [31:0] pwdata, prdata, r, v, rip, lip, rports;
  logic [47:0] mac;
  logic [15:0] lport, plen;
  logic [31:0] mdl [16];
  int error_cnt, comparisons, req_cnt, rep_cnt, tx_cnt, seed;

  uocr_if uocr_if_inst ();
  // Pulses: byte done, reply, request, buffer full, checksum, mac error
  uocr_core_regs #(.CORE_VERSION(VERSION)) uocr_core_regs_inst
  (
    .pclk(pclk), .presetn(presetn), .ifc(uocr_if_inst),
    .net_tx_byte_done(np[0]), .net_arp_reply_rx(np[1]),
    .net_arp_request_rx(np[2]), .net_drop_buf_full(np[3]),
    .net_drop_checksum(np[4]), .mac_rx_error_flag(np[5]),
    .net_tx_ready(1'b1), .net_rx_data(rx_byte), .net_rx_empty(1'b0),
    .net_arp_request_tx(req_tx), .net_arp_reply_tx(rep_tx),
    .net_link_ready(), .net_local_mac(mac), .net_remote_ip(rip),
    .net_local_ip(lip), .net_remote_ports(rports), .net_local_port(lport),
    .net_role_server(srole), .net_packet_length(plen),
    .net_tx_valid(tx_valid), .net_tx_data(tx_data), .net_rx_pop()
  );
  uocr_user_ctrl uocr_user_ctrl_inst
  (
    .pclk(pclk), .presetn(presetn), .ifc(uocr_if_inst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  uocr_ctl_chk #(.CORE_VERSION(VERSION)) uocr_ctl_chk_inst
  (
    .pclk(pclk), .presetn(presetn),
    .reg_port_address(uocr_if_inst.reg_port_address),
    .reg_port_write_data(uocr_if_inst.reg_port_write_data),
    .reg_port_write_enable(uocr_if_inst.reg_port_write_enable),
    .reg_port_read_data(uocr_if_inst.reg_port_read_data),
    .busy(uocr_if_inst.busy), .interrupt_out(uocr_if_inst.interrupt_out)
  );

  // Clock
  always #5 pclk = ~pclk;

  // Tally pulses out of the core, pre-edge values only
  always @(posedge pclk)
  begin
    req_cnt += int'(req_tx === 1'b1);
    rep_cnt += int'(rep_tx === 1'b1);
    if (tx_valid === 1'b1)
    begin
      tx_cnt++;
      tx_last = tx_data;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    if (error_cnt == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task automatic hang();
    error_cnt++;
    end_sim();
  endtask : hang

  function automatic int obs(input int k);
    case (k)
      0: return req_cnt;
      1: return rep_cnt;
      2: return tx_cnt;
      3: return int'(uocr_if_inst.busy === 1'b0);
      default: return int'(uocr_if_inst.interrupt_out === 1'b1);
    endcase
  endfunction : obs

  // Bounded wait on a count or level; a run-out ends the run
  task automatic waitc(input int k, input int lim);
    int n;
    n = 0;
    while (obs(k) < lim && n < 3000)
    begin
      @(negedge pclk);
      n++;
    end
    if (n == 3000) hang();
  endtask : waitc

  // One APB transfer; pready and prdata taken at the completing edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) hang();
  endtask : apb

  // Register port access ordered through the host, then polled to idle
  task automatic ra(input logic w, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    apb(1'b1, APB_WDATA, d, q);
    apb(1'b1, APB_CTRL, {24'h0, a, 2'b00, w, 1'b1}, q);
    do
    begin
      apb(1'b0, APB_STATUS, 32'h0, q);
      n++;
    end
    while (q[HST_PENDING] !== 1'b0 && n < 20);
    if (n == 20) hang();
    apb(1'b0, APB_RDATA, 32'h0, q);
  endtask : ra

  task automatic pulse(input int i);
    @(posedge pclk);
    np[i] <= 1'b1;
    @(posedge pclk);
    np[i] <= 1'b0;
  endtask : pulse

  initial
  begin
    int rl [5] = '{0, 10, 14, 15, 11};
    seed = 32'h5cf7;
    {psel, penable, pwrite, paddr, pwdata, np} = '0;
    rx_byte = 8'($random(seed));
    mdl = '{default: 32'h0};
    mdl[0] = 32'h1;
    mdl[10] = 32'h5c0;
    mdl[15] = VERSION;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk(uocr_if_inst.busy, 1);
    chk(plen, 16'h5c0);
    // Reset values, version and an unmapped hole
    foreach (rl[i])
    begin
      ra(1'b0, 4'(rl[i]), 0, r);
      chk(r, mdl[rl[i]]);
    end
    // Random parameters; 0xc is unmapped and must stay zero
    for (int a = 2; a < 13; a++)
    begin
      if (a > 7 && a < 12) continue;
      v = $random(seed);
      ra(1'b1, 4'(a), v, r);
      mdl[a] = (a == 3 || a == 7) ? v & 32'hffff : (a == 12 ? 0 : v);
    end
    for (int a = 2; a < 13; a++)
    begin
      if (a > 7 && a < 12) continue;
      ra(1'b0, 4'(a), 0, r);
      chk(r, mdl[a]);
    end
    // Client start-up; the first reply wait runs out on purpose
    ra(1'b1, ADDR_ARP_TIMEOUT_STATUS, 32'hc8, r);
    ra(1'b1, ADDR_RESET_CONTROL, 32'h0, r);
    waitc(0, 1);
    chk(mac[31:0], mdl[2]);
    chk({16'h0, mac[47:32]}, mdl[3]);
    chk(rip, mdl[4]);
    chk(lip, mdl[5]);
    chk(rports, mdl[6]);
    chk({16'h0, lport}, mdl[7]);
    waitc(0, 2);
    waitc(4, 1);
    ra(1'b0, ADDR_ARP_TIMEOUT_STATUS, 0, r);
    chk(r, 32'h1);
    pulse(1);
    waitc(3, 1);
    // Three-byte send, remaining count read before each byte
    ra(1'b1, ADDR_TX_TOTAL_LENGTH, 32'h3, r);
    ra(1'b1, ADDR_SEND_COMMAND, 32'h1, r);
    ra(1'b0, ADDR_SEND_COMMAND, 0, r);
    chk(r & 32'h1, 1);
    for (int i = 3; i > 0; i--)
    begin
      ra(1'b0, ADDR_TX_TOTAL_LENGTH, 0, r);
      chk(r, i);
      pulse(0);
    end
    waitc(3, 1);
    // Second send reuses the stored total length
    ra(1'b1, ADDR_SEND_COMMAND, 32'h1, r);
    ra(1'b0, ADDR_TX_TOTAL_LENGTH, 0, r);
    chk(r, 3);
    repeat (3) pulse(0);
    waitc(3, 1);
    ra(1'b0, ADDR_TX_TOTAL_LENGTH, 0, r);
    chk(r, 0);
    // Drop causes; address moved off after each clearing read
    for (int i = 0; i < 3; i++)
    begin
      pulse(3 + i);
      ra(1'b0, ADDR_ARP_TIMEOUT_STATUS, 0, r);
      chk(r, 32'h100 << i);
      ra(1'b0, ADDR_RESET_CONTROL, 0, r);
    end
    // Server role: wait for the remote request, answer, go idle
    ra(1'b1, ADDR_RESET_CONTROL, 32'h1, r);
    ra(1'b1, ADDR_ROLE_SELECT, 32'h1, r);
    ra(1'b1, ADDR_RESET_CONTROL, 32'h0, r);
    chk(uocr_if_inst.busy, 1);
    chk(rep_cnt, 0);
    pulse(2);
    waitc(1, 1);
    waitc(3, 1);
    chk(srole, 1);
    // Payload bytes both ways through the host
    apb(1'b1, APB_TX_BYTE, 32'h5a, r);
    waitc(2, 1);
    chk(tx_last, 8'h5a);
    apb(1'b1, APB_RX_BYTE, 0, r);
    apb(1'b0, APB_STATUS, 0, r);
    apb(1'b0, APB_RX_BYTE, 0, r);
    chk(r[7:0], rx_byte);
    end_sim();
  end
endmodule : tb
